// File: hw/counter_pkg.sv
/*
 package for the four-channel fast up/down counter block.
 assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package counter_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int CHANNELS = 4;
    localparam int ADDR_W = 8;
    localparam logic signed [31:0] COUNT_MAX = 32'sh7fffffff;
    localparam logic signed [31:0] COUNT_MIN = 32'sh80000000;
    localparam logic [3:0] PEND_MAX = 4'hf;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCAN_TIME_NS = 1000000;
    localparam int SCAN_CYCLES = SCAN_TIME_NS / CLK_PERIOD_NS;
    // ----------------------------------------
    // register map, per channel at ch * 0x20
    // ----------------------------------------
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_UPPER = 5'h04;
    localparam logic [4:0] OFF_LOWER = 5'h08;
    localparam logic [4:0] OFF_PRESET = 5'h0c;
    localparam logic [4:0] OFF_COUNT = 5'h10;
    localparam logic [4:0] OFF_FLAGS = 5'h14;
    localparam logic [7:0] OFF_RUN = 8'h80;
    // control bits
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_EN_EVAL = 1;
    localparam int CTRL_DIR = 2;
    localparam int CTRL_LOAD = 3;
    localparam int CTRL_CLEAR = 4;
    localparam int CTRL_RETAIN = 5;
    // reset values
    localparam logic [5:0] CTRL_RST = 6'h02;
    localparam logic [31:0] THRESH_RST = 32'h00000000;
    localparam logic RUN_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hw/fast_counter_channel.sv
/*
 one fast up/down counter channel with threshold, zero and carry flags.
 assumes a raw pulse pin and a one-cycle scan tick from the parent.
*/
module fast_counter_channel
    import counter_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstSyncN,
    input wire logic pulsePin,
    input wire logic run,
    input wire logic enable,
    input wire logic enEval,
    input wire logic dir,
    input wire logic presetLoad,
    input wire logic counterClear,
    input wire logic retentive,
    input wire logic scanTick,
    input wire logic signed [31:0] upperThreshold,
    input wire logic signed [31:0] lowerThreshold,
    input wire logic signed [31:0] presetValue,
    output logic signed [31:0] countValue,
    output logic upperReachedFlag,
    output logic lowerReachedFlag,
    output logic zeroFlag,
    output logic rangeCarryFlag
);
    import counter_pkg::*;
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prevIn;
        logic prevLoad;
        logic prevRun;
        logic signed [31:0] count;
        logic upper;
        logic lower;
        logic zero;
        logic carry;
        logic [3:0] pending;
    } chan_state_t;
    chan_state_t st, next;
    logic risePulse, loadEdge, stopEdge, active, ovf;

    always_comb begin
        next = st;
        // pulses must stay high and low two clocks each
        next.sync1 = pulsePin;
        next.sync2 = st.sync1;
        next.prevIn = st.sync2;
        next.prevLoad = presetLoad;
        next.prevRun = run;
        risePulse = st.sync2 && !st.prevIn;
        loadEdge = presetLoad && !st.prevLoad;
        stopEdge = st.prevRun && !run;
        active = run && (!enEval || enable);
        ovf = 1'b0;
        if (counterClear) begin
            next.count = '0;
        end else if (loadEdge) begin
            next.count = presetValue;
        end else if (stopEdge && !retentive) begin
            next.count = '0;
        end else if (active && risePulse) begin
            // counts on pin edges, not on the scan
            if (!dir) begin
                if (st.count == COUNT_MAX) ovf = 1'b1;
                else next.count = st.count + 32'sd1;
            end else begin
                if (st.count == COUNT_MIN) ovf = 1'b1;
                else next.count = st.count - 32'sd1;
            end
        end
        // one scan of carry per overflow edge, queued up to PEND_MAX (15)
        if (scanTick) next.carry = (st.pending != 4'h0);
        if (ovf && !(scanTick && st.pending != 4'h0)) begin
            if (st.pending != PEND_MAX) next.pending = st.pending + 4'h1;
        end else if (!ovf && scanTick && st.pending != 4'h0) begin
            next.pending = st.pending - 4'h1;
        end
        next.upper = next.count >= upperThreshold;
        next.lower = next.count <= lowerThreshold;
        next.zero = next.count == 32'sd0;
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            st <= '{sync1: 1'b0, sync2: 1'b0, prevIn: 1'b0, prevLoad: 1'b0, prevRun: 1'b0,
                   count: 32'sd0, upper: 1'b1, lower: 1'b1, zero: 1'b1, carry: 1'b0,
                   pending: 4'h0};
        end else begin
            st <= next;
        end
    end

    assign countValue = st.count;
    assign upperReachedFlag = st.upper;
    assign lowerReachedFlag = st.lower;
    assign zeroFlag = st.zero;
    assign rangeCarryFlag = st.carry;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstSyncN);
    sequence upStep;
        active && risePulse && !counterClear && !loadEdge && !stopEdge && !dir;
    endsequence
    clear_forces_zero_a: assert property (counterClear |=> st.count == 32'sd0)
        else $error("clear did not zero the count");
    preset_load_a: assert property (loadEdge && !counterClear
        |=> st.count == $past(presetValue))
        else $error("preset edge did not load");
    count_up_a: assert property (upStep ##0 st.count != COUNT_MAX
        |=> st.count == $past(st.count) + 32'sd1)
        else $error("up count step wrong");
    disabled_hold_a: assert property (enEval && !enable && !counterClear && !loadEdge
        && !stopEdge |=> $stable(st.count))
        else $error("disabled channel counted");
    upper_flag_a: assert property (st.upper == (st.count >= $past(upperThreshold)))
        else $error("upper flag wrong");
    lower_flag_a: assert property (st.lower == (st.count <= $past(lowerThreshold)))
        else $error("lower flag wrong");
    overflow_hold_a: assert property (ovf |=> $stable(st.count) && st.pending != 4'h0)
        else $error("overflow wrapped or was lost");
    carry_scan_a: assert property (scanTick && st.pending != 4'h0 |=> st.carry)
        else $error("carry not shown for the scan");
endmodule

// File: hw/fast_counter_top.sv
/*
 four fast up/down pulse counters behind an AXI4-Lite register slave.
 assumes pulse pins asynchronous to sys_clk and one write and one
 read in flight at most on the bus.
*/
// ----------------------------------------
// How it works
// - four independent counters, each with own flags
// - pulse input n feeds channel n
// - counting follows pin edges, not scan
// - enable gates channel when evaluation selected
// - evaluation off: channel active whenever run is set
// - direction 0 counts up, 1 down
// - preset-load rising edge copies preset value
// - clear held forces count to zero
// - upper flag when count >= upper threshold
// - lower flag when count <= lower threshold
// - zero flag when count equals zero
// - carry one scan per overflow edge, up to 15 queued
// - overflow keeps last valid count, no wrap
// - count is signed 32-bit full range
// - retentive channel keeps count across stop
// ----------------------------------------
module fast_counter_top
    import counter_pkg::*;
#(
    parameter int SCAN_LEN = counter_pkg::SCAN_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] pulseIn,
    input wire logic [counter_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [counter_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import counter_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic awHave;
        logic wHave;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic run;
        logic [3:0][5:0] ctrl;
        logic [3:0][31:0] upper;
        logic [3:0][31:0] lower;
        logic [3:0][31:0] preset;
        logic [16:0] scanCnt;
        logic scanTick;
    } top_state_t;
    top_state_t st, next;

    logic [1:0] rstPipe;
    logic rstSyncN;
    logic wrFire;
    logic [1:0] wrCh;
    logic [1:0] rdCh;
    logic [4:0] wrOff;
    logic [4:0] rdOff;
    logic [31:0] rdVal;
    logic rdErr;
    logic signed [3:0][31:0] count;
    logic [3:0][3:0] flags;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe[1];

    // byte-lane merge for a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) r[8*b +: 8] = d[8*b +: 8];
        end
        return r;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next = st;
        wrFire = st.awHave && st.wHave && !st.bvalid;
        wrCh = st.awAddr[6:5];
        wrOff = st.awAddr[4:0];
        rdCh = araddr[6:5];
        rdOff = araddr[4:0];
        rdVal = 32'h00000000;
        rdErr = 1'b0;

        // scan period; carry flag timing hangs off this tick, other flags follow the count each clock
        next.scanTick = 1'b0;
        if (st.scanCnt == 17'(SCAN_LEN - 1)) begin
            next.scanCnt = 17'h00000;
            next.scanTick = 1'b1;
        end else begin
            next.scanCnt = st.scanCnt + 17'h00001;
        end

        // write channel
        if (st.bvalid && bready) next.bvalid = 1'b0;
        if (awvalid && st.awready) begin
            next.awHave = 1'b1;
            next.awAddr = awaddr;
        end
        if (wvalid && st.wready) begin
            next.wHave = 1'b1;
            next.wData = wdata;
            next.wStrb = wstrb;
        end
        if (wrFire) begin
            next.awHave = 1'b0;
            next.wHave = 1'b0;
            next.bvalid = 1'b1;
            next.bresp = RESP_OKAY;
            if (st.awAddr == OFF_RUN) begin
                if (st.wStrb[0]) next.run = st.wData[0];
            end else if (st.awAddr[7]) begin
                next.bresp = RESP_SLVERR;
            end else if (wrOff == OFF_CTRL) begin
                if (st.wStrb[0]) next.ctrl[wrCh] = st.wData[5:0];
            end else if (wrOff == OFF_UPPER) begin
                next.upper[wrCh] = merge(st.upper[wrCh], st.wData, st.wStrb);
            end else if (wrOff == OFF_LOWER) begin
                next.lower[wrCh] = merge(st.lower[wrCh], st.wData, st.wStrb);
            end else if (wrOff == OFF_PRESET) begin
                next.preset[wrCh] = merge(st.preset[wrCh], st.wData, st.wStrb);
            end else if (wrOff == OFF_COUNT || wrOff == OFF_FLAGS) begin
                // read-only words: write dropped, answer stays OKAY
                next.bresp = RESP_OKAY;
            end else begin
                next.bresp = RESP_SLVERR;
            end
        end
        next.awready = !next.awHave && !next.bvalid;
        next.wready = !next.wHave && !next.bvalid;

        // read channel
        if (araddr == OFF_RUN) begin
            rdVal = {31'h00000000, st.run};
        end else if (araddr[7]) begin
            rdErr = 1'b1;
        end else if (rdOff == OFF_CTRL) begin
            rdVal = {26'h0000000, st.ctrl[rdCh]};
        end else if (rdOff == OFF_UPPER) begin
            rdVal = st.upper[rdCh];
        end else if (rdOff == OFF_LOWER) begin
            rdVal = st.lower[rdCh];
        end else if (rdOff == OFF_PRESET) begin
            rdVal = st.preset[rdCh];
        end else if (rdOff == OFF_COUNT) begin
            rdVal = count[rdCh];
        end else if (rdOff == OFF_FLAGS) begin
            rdVal = {28'h0000000, flags[rdCh]};
        end else begin
            rdErr = 1'b1;
        end
        if (st.rvalid && rready) next.rvalid = 1'b0;
        if (arvalid && st.arready) begin
            next.rvalid = 1'b1;
            next.rdata = rdVal;
            next.rresp = rdErr ? RESP_SLVERR : RESP_OKAY;
        end
        next.arready = !next.rvalid;
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            st <= '{
                awready: 1'b1,
                wready: 1'b1,
                bvalid: 1'b0,
                bresp: RESP_OKAY,
                arready: 1'b1,
                rvalid: 1'b0,
                rresp: RESP_OKAY,
                rdata: 32'h00000000,
                awHave: 1'b0,
                wHave: 1'b0,
                awAddr: 8'h00,
                wData: 32'h00000000,
                wStrb: 4'h0,
                run: RUN_RST,
                ctrl: {4{CTRL_RST}},
                upper: {4{THRESH_RST}},
                lower: {4{THRESH_RST}},
                preset: {4{THRESH_RST}},
                scanCnt: 17'h00000,
                scanTick: 1'b0
            };
        end else begin
            st <= next;
        end
    end

    // ----------------------------------------
    // counter channels
    // ----------------------------------------
    // pins are raw; each channel synchronises its own pin
    for (genvar i = 0; i < CHANNELS; i++) begin : chan
        fast_counter_channel u_chan (
            .sys_clk(sys_clk),
            .rstSyncN(rstSyncN),
            .pulsePin(pulseIn[i]),
            .run(st.run),
            .enable(st.ctrl[i][CTRL_ENABLE]),
            .enEval(st.ctrl[i][CTRL_EN_EVAL]),
            .dir(st.ctrl[i][CTRL_DIR]),
            .presetLoad(st.ctrl[i][CTRL_LOAD]),
            .counterClear(st.ctrl[i][CTRL_CLEAR]),
            .retentive(st.ctrl[i][CTRL_RETAIN]),
            .scanTick(st.scanTick),
            .upperThreshold(st.upper[i]),
            .lowerThreshold(st.lower[i]),
            .presetValue(st.preset[i]),
            .countValue(count[i]),
            .upperReachedFlag(flags[i][0]),
            .lowerReachedFlag(flags[i][1]),
            .zeroFlag(flags[i][2]),
            .rangeCarryFlag(flags[i][3])
        );
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence wrCtrl0;
        wrFire && st.awAddr == {3'h0, OFF_CTRL} && st.wStrb[0];
    endsequence
    sequence countRead;
        arvalid && st.arready && !araddr[7] && araddr[4:0] == OFF_COUNT;
    endsequence

    wr_resp_follows_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        wrFire |=> st.bvalid ##0 !st.awready && !st.wready)
        else $error("write response missing");

    bresp_held_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        st.bvalid && !bready |=> st.bvalid && $stable(st.bresp))
        else $error("write response dropped early");

    rd_answer_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        arvalid && st.arready |=> st.rvalid && !st.arready)
        else $error("read answer missing");

    rdata_held_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        st.rvalid && !rready |=> st.rvalid && $stable(st.rdata))
        else $error("read data changed while waiting");

    ctrl_write_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        wrCtrl0 |=> st.ctrl[0] == $past(st.wData[5:0]))
        else $error("control write not stored");

    count_read_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        countRead |=> st.rdata == $past(count[rdCh]))
        else $error("count read mismatch");

    scan_period_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        st.scanTick |=> !st.scanTick)
        else $error("scan tick longer than one cycle");

    ready_low_busy_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        st.bvalid |-> !st.awready && !st.wready)
        else $error("write channels open during response");

    bresp_release_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        st.bvalid && bready |=> !st.bvalid)
        else $error("write response not released");

    rdata_release_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        st.rvalid && rready |=> !st.rvalid && st.arready)
        else $error("read answer not released");

    aw_capture_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        awvalid && st.awready |=> st.awHave && st.awAddr == $past(awaddr))
        else $error("write address not captured");

    wr_refused_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        wrFire && st.awAddr[7] && st.awAddr != OFF_RUN |=> st.bresp == RESP_SLVERR)
        else $error("unmapped write not refused");

    rd_refused_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        arvalid && st.arready && rdErr |=> st.rresp == RESP_SLVERR && st.rdata == 32'h0)
        else $error("unmapped read not refused");

    run_write_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        wrFire && st.awAddr == OFF_RUN && st.wStrb[0] |=> st.run == $past(st.wData[0]))
        else $error("run write not stored");

    upper_write_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        wrFire && st.awAddr == {3'h0, OFF_UPPER} && st.wStrb == 4'hf
        |=> st.upper[0] == $past(st.wData))
        else $error("upper threshold write not stored");
endmodule

// File: bench/pulse_source.sv
/*
 far-side model: a square-wave pulse source on the four count pins.
 assumes the bench requests bursts on go, with the pulse count on nPulses.
*/
module pulse_source #(
    parameter int HALF = 3
) (
    input wire logic sys_clk,
    input wire logic [3:0] go,
    input wire logic [7:0] nPulses,
    output logic [3:0] pulseOut,
    output logic [3:0] busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // burst generator
    // ----------------------------------------
    int left [4];
    int phase [4];
    initial begin
        pulseOut = 4'h0;
        for (int i = 0; i < 4; i++) begin
            left[i] = 0;
            phase[i] = 0;
        end
    end
    // one pin per channel, idle low between bursts
    always @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (go[i] && left[i] == 0) begin
                left[i] <= 2 * int'(nPulses);
                phase[i] <= 0;
            end else if (left[i] != 0) begin
                // equal high and low time; HALF kept >= 2 so sync never misses a level
                if (phase[i] == HALF - 1) begin
                    phase[i] <= 0;
                    pulseOut[i] <= ~pulseOut[i];
                    left[i] <= left[i] - 1;
                end else begin
                    phase[i] <= phase[i] + 1;
                end
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            busy[i] = (left[i] != 0);
        end
    end
endmodule

// File: bench/fast_updown_threshold_counter_tb_top.sv
/*
 bench top: AXI4-Lite register tasks and a pulse source around the counter block.
 assumes the design package; scan shortened to 8 clocks so carry pulses stay short.
*/
module fast_updown_threshold_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import counter_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] pulseIn, busy;
    logic [3:0] go = 4'h0;
    logic [7:0] nPulses = 8'h00;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int errorCnt = 0;
    int totalChecks = 0;
    always #10 sys_clk = ~sys_clk;
    fast_counter_top #(.SCAN_LEN(8)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .pulseIn(pulseIn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    pulse_source #(.HALF(3)) src_u (.sys_clk(sys_clk), .go(go), .nPulses(nPulses),
        .pulseOut(pulseIn), .busy(busy));
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic testDone();
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic timeOut();
        errorCnt++;
        $display("ERROR at %0t: wait ran out, seen %h expected %h", $time, 1'b0, 1'b1);
        testDone();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ----------------------------------------
    // bus tasks; handshakes judged on settled values at the falling edge
    // ----------------------------------------
    function automatic logic [7:0] ra(input int ch, input logic [4:0] off);
        return 8'(ch * 32) + {3'b000, off};
    endfunction
    // all control writes go through this one task
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic awHs, wHs, done;
        done = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge sys_clk);
            awHs = awvalid && awready;
            wHs = wvalid && wready;
            done = bvalid && bready;
            resp = bresp;
            @(posedge sys_clk);
            if (awHs) awvalid <= 1'b0;
            if (wHs) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        if (!done) timeOut();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic arHs, done;
        done = 1'b0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge sys_clk);
            arHs = arvalid && arready;
            done = rvalid && rready;
            d = rdata;
            resp = rresp;
            @(posedge sys_clk);
            if (arHs) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) timeOut();
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp);
    endtask
    task automatic countsAre(input logic [31:0] e0, e1, e2, e3);
        rdChk(ra(0, OFF_COUNT), e0);
        rdChk(ra(1, OFF_COUNT), e1);
        rdChk(ra(2, OFF_COUNT), e2);
        rdChk(ra(3, OFF_COUNT), e3);
    endtask
    // ----------------------------------------
    // pulse tasks
    // ----------------------------------------
    task automatic pulseStart(input logic [3:0] mask, input logic [7:0] n);
        @(posedge sys_clk);
        go <= mask;
        nPulses <= n;
        @(posedge sys_clk);
        go <= 4'h0;
    endtask
    task automatic pulseWait();
        int k;
        // busy rises one edge after go; look only once it can have risen
        @(negedge sys_clk);
        for (k = 0; k < 2000 && busy !== 4'h0; k++) @(negedge sys_clk);
        if (busy !== 4'h0) timeOut();
        repeat (6) @(posedge sys_clk);
    endtask
    // carry lasts only a scan or two, so flags are polled while pulses run
    task automatic carryRun(input int ch, input logic [3:0] mask);
        logic [31:0] d;
        logic [1:0] r;
        logic seen;
        seen = 1'b0;
        pulseStart(mask, 8'd3);
        for (int k = 0; k < 40 && !seen; k++) begin
            rd(ra(ch, OFF_FLAGS), d, r);
            seen = d[3];
        end
        chk({31'h0, seen}, 32'h1);
        pulseWait();
        repeat (60) @(posedge sys_clk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rdChk(ra(0, OFF_CTRL), 32'h2);
        rdChk(ra(1, OFF_FLAGS), 32'h7);
        rdChk(OFF_RUN, 32'h1);
        rd(ra(0, 5'h18), d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0);
        wr(8'h84, 32'h1, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(ra(0, OFF_CTRL), 32'h03, r);
        wr(ra(1, OFF_CTRL), 32'h02, r);
        wr(ra(2, OFF_CTRL), 32'h00, r);
        wr(ra(3, OFF_CTRL), 32'h05, r);
        pulseStart(4'hf, 8'd3);
        pulseWait();
        countsAre(3, 0, 3, -3);
        pulseStart(4'h1, 8'd2);
        pulseWait();
        countsAre(5, 0, 3, -3);
        wr(ra(0, OFF_UPPER), 32'd5, r);
        wr(ra(0, OFF_LOWER), 32'd2, r);
        wr(ra(3, OFF_LOWER), -3, r);
        rdChk(ra(0, OFF_FLAGS), 32'h1);
        rdChk(ra(3, OFF_FLAGS), 32'h2);
        wr(ra(0, OFF_PRESET), 32'h7ffffffe, r);
        wr(ra(0, OFF_CTRL), 32'h0b, r);
        rdChk(ra(0, OFF_COUNT), 32'h7ffffffe);
        carryRun(0, 4'h1);
        rdChk(ra(0, OFF_COUNT), 32'h7fffffff);
        rdChk(ra(0, OFF_FLAGS), 32'h1);
        wr(ra(3, OFF_PRESET), 32'h80000001, r);
        wr(ra(3, OFF_CTRL), 32'h0d, r);
        carryRun(3, 4'h8);
        rdChk(ra(3, OFF_COUNT), 32'h80000000);
        rdChk(ra(3, OFF_FLAGS), 32'h2);
        wr(ra(0, OFF_CTRL), 32'h13, r);
        pulseStart(4'h1, 8'd2);
        pulseWait();
        rdChk(ra(0, OFF_COUNT), 32'h0);
        rdChk(ra(0, OFF_FLAGS), 32'h6);
        wr(ra(0, OFF_CTRL), 32'h03, r);
        pulseStart(4'h1, 8'd1);
        pulseWait();
        rdChk(ra(0, OFF_COUNT), 32'h1);
        wr(ra(0, OFF_CTRL), 32'h1b, r);
        rdChk(ra(0, OFF_COUNT), 32'h0);
        wr(ra(0, OFF_CTRL), 32'h03, r);
        wr(ra(2, OFF_CTRL), 32'h20, r);
        pulseStart(4'h1, 8'd2);
        pulseWait();
        wr(OFF_RUN, 32'h0, r);
        pulseStart(4'h5, 8'd2);
        pulseWait();
        wr(OFF_RUN, 32'h1, r);
        countsAre(0, 0, 3, 0);
        pulseStart(4'h4, 8'd1);
        pulseWait();
        rdChk(ra(2, OFF_COUNT), 32'h4);
        testDone();
    end
endmodule
